/* File: logic/ipr_regs.v */
// Six interrupt priority registers with an APB slave and arbitration output
// Assumes APB master on pclk; source requests are synchronous to pclk
//
// Contract
// [R1] A 3-bit field holds its source level directly, 1 lowest, 7 highest.
// [R2] Level zero disables the source; its request is never forwarded.
// [R3] Unimplemented bits read zero and ignore writes.
// [R4] Every field resets to level four.
// [R5] Implemented field bits are read/write and return the last written value.
// [R6] Register 1: timer2, output compare 2, input capture 2, DMA 0.
// [R7] Register 2: UART1 receive, SPI1 event, SPI1 error, timer3.
// [R8] Register 3: top bits unused, DMA 1, ADC1, UART1 transmit.
// [R9] Register 4: change notify, comparator, I2C1 master, I2C1 slave.
// [R10] Register 5: input capture 8 and 7, bits 7-3 unused, external irq 1.
// [R11] Register 6: timer4, output compare 4, output compare 3, DMA 2.
// [R12] Current levels are always presented to the arbitration logic.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "ipr_map.vh"
module ipr_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [`IPR_NSRC-1:0] src_req,
    output reg [2:0] timer2_level,
    output reg [2:0] out_compare2_level,
    output reg [2:0] in_capture2_level,
    output reg [2:0] dma_chan0_done_level,
    output reg [2:0] uart1_receive_level,
    output reg [2:0] spi1_event_level,
    output reg [2:0] spi1_error_level,
    output reg [2:0] timer3_level,
    output reg [2:0] dma_chan1_done_level,
    output reg [2:0] adc1_done_level,
    output reg [2:0] uart1_transmit_level,
    output reg [2:0] change_notify_level,
    output reg [2:0] comparator_level,
    output reg [2:0] i2c1_master_level,
    output reg [2:0] i2c1_slave_level,
    output reg [2:0] in_capture8_level,
    output reg [2:0] in_capture7_level,
    output reg [2:0] ext_irq1_level,
    output reg [2:0] timer4_level,
    output reg [2:0] out_compare4_level,
    output reg [2:0] out_compare3_level,
    output reg [2:0] dma_chan2_done_level,
    output reg irq_valid,
    output reg [4:0] irq_id,
    output reg [2:0] irq_level
);

    // ======================================================
    // Register storage
    reg [15:0] int_priority_reg_1;
    reg [15:0] int_priority_reg_2;
    reg [15:0] int_priority_reg_3;
    reg [15:0] int_priority_reg_4;
    reg [15:0] int_priority_reg_5;
    reg [15:0] int_priority_reg_6;
    reg [1:0] state_reg;
    reg [1:0] state_next;

    // Bus phase tracker, one-hot: idle, or answering in the access phase
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ANSWER = 2'b10;

    wire setup = psel && !penable;
    wire acc_phase = psel && penable;
    // A write lands only at the edge that completes the access phase
    wire wr_en = acc_phase && pready && pwrite;
    wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Merge write data into implemented bits only
    function [15:0] ipr_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input [15:0] impl;
        input [15:0] lanes;
        reg [15:0] m;
        begin
            m = impl & lanes;
            ipr_merge = (old_val & ~m) | (new_val & m); // [R3] [R5]
        end
    endfunction

    function [2:0] ipr_field;
        input [15:0] r;
        input integer lsb;
        begin
            ipr_field = r[lsb +: 3]; // [R1]
        end
    endfunction

    // Read view of a register: unused bits forced low
    function [31:0] ipr_read;
        input [15:0] r;
        input [15:0] impl;
        begin
            ipr_read = {16'h0000, r & impl}; // [R3]
        end
    endfunction

    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `IPR_OFF_PRI1) ||
                (a == `IPR_OFF_PRI2) ||
                (a == `IPR_OFF_PRI3) ||
                (a == `IPR_OFF_PRI4) ||
                (a == `IPR_OFF_PRI5) ||
                (a == `IPR_OFF_PRI6) ||
                (a == `IPR_OFF_PEND) ||
                (a == `IPR_OFF_WIN);
        end
    endfunction

    // ======================================================
    // Register writes, taken in the access cycle, committed at access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_priority_reg_1 <= `IPR_RST_FULL; // [R4]
            int_priority_reg_2 <= `IPR_RST_FULL; // [R4]
            int_priority_reg_3 <= `IPR_RST_PRI3; // [R4]
            int_priority_reg_4 <= `IPR_RST_FULL; // [R4]
            int_priority_reg_5 <= `IPR_RST_PRI5; // [R4]
            int_priority_reg_6 <= `IPR_RST_FULL; // [R4]
        end else if (wr_en) begin
            case (paddr)
                `IPR_OFF_PRI1: begin
                    int_priority_reg_1 <= ipr_merge(int_priority_reg_1,
                        pwdata[15:0], `IPR_MASK_FULL, lane_mask); // [R6]
                end
                `IPR_OFF_PRI2: begin
                    int_priority_reg_2 <= ipr_merge(int_priority_reg_2,
                        pwdata[15:0], `IPR_MASK_FULL, lane_mask); // [R7]
                end
                `IPR_OFF_PRI3: begin
                    int_priority_reg_3 <= ipr_merge(int_priority_reg_3,
                        pwdata[15:0], `IPR_MASK_PRI3, lane_mask); // [R8]
                end
                `IPR_OFF_PRI4: begin
                    int_priority_reg_4 <= ipr_merge(int_priority_reg_4,
                        pwdata[15:0], `IPR_MASK_FULL, lane_mask); // [R9]
                end
                `IPR_OFF_PRI5: begin
                    int_priority_reg_5 <= ipr_merge(int_priority_reg_5,
                        pwdata[15:0], `IPR_MASK_PRI5, lane_mask); // [R10]
                end
                `IPR_OFF_PRI6: begin
                    int_priority_reg_6 <= ipr_merge(int_priority_reg_6,
                        pwdata[15:0], `IPR_MASK_FULL, lane_mask); // [R11]
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================
    // Level outputs, registered copies of the fields
    wire [`IPR_NSRC*3-1:0] level_vec = {
        ipr_field(int_priority_reg_6, `IPR_FLD_LO),
        ipr_field(int_priority_reg_6, `IPR_FLD_ML),
        ipr_field(int_priority_reg_6, `IPR_FLD_MH),
        ipr_field(int_priority_reg_6, `IPR_FLD_HI),
        ipr_field(int_priority_reg_5, `IPR_FLD_LO),
        ipr_field(int_priority_reg_5, `IPR_FLD_MH),
        ipr_field(int_priority_reg_5, `IPR_FLD_HI),
        ipr_field(int_priority_reg_4, `IPR_FLD_LO),
        ipr_field(int_priority_reg_4, `IPR_FLD_ML),
        ipr_field(int_priority_reg_4, `IPR_FLD_MH),
        ipr_field(int_priority_reg_4, `IPR_FLD_HI),
        ipr_field(int_priority_reg_3, `IPR_FLD_LO),
        ipr_field(int_priority_reg_3, `IPR_FLD_ML),
        ipr_field(int_priority_reg_3, `IPR_FLD_MH),
        ipr_field(int_priority_reg_2, `IPR_FLD_LO),
        ipr_field(int_priority_reg_2, `IPR_FLD_ML),
        ipr_field(int_priority_reg_2, `IPR_FLD_MH),
        ipr_field(int_priority_reg_2, `IPR_FLD_HI),
        ipr_field(int_priority_reg_1, `IPR_FLD_LO),
        ipr_field(int_priority_reg_1, `IPR_FLD_ML),
        ipr_field(int_priority_reg_1, `IPR_FLD_MH),
        ipr_field(int_priority_reg_1, `IPR_FLD_HI)
    };

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer2_level <= `IPR_LVL_RST; // [R4]
            out_compare2_level <= `IPR_LVL_RST;
            in_capture2_level <= `IPR_LVL_RST;
            dma_chan0_done_level <= `IPR_LVL_RST;
            uart1_receive_level <= `IPR_LVL_RST;
            spi1_event_level <= `IPR_LVL_RST;
            spi1_error_level <= `IPR_LVL_RST;
            timer3_level <= `IPR_LVL_RST;
            dma_chan1_done_level <= `IPR_LVL_RST;
            adc1_done_level <= `IPR_LVL_RST;
            uart1_transmit_level <= `IPR_LVL_RST;
            change_notify_level <= `IPR_LVL_RST;
            comparator_level <= `IPR_LVL_RST;
            i2c1_master_level <= `IPR_LVL_RST;
            i2c1_slave_level <= `IPR_LVL_RST;
            in_capture8_level <= `IPR_LVL_RST;
            in_capture7_level <= `IPR_LVL_RST;
            ext_irq1_level <= `IPR_LVL_RST;
            timer4_level <= `IPR_LVL_RST;
            out_compare4_level <= `IPR_LVL_RST;
            out_compare3_level <= `IPR_LVL_RST;
            dma_chan2_done_level <= `IPR_LVL_RST;
        end else begin
            timer2_level <= ipr_field(int_priority_reg_1, `IPR_FLD_HI); // [R6] [R12]
            out_compare2_level <= ipr_field(int_priority_reg_1, `IPR_FLD_MH);
            in_capture2_level <= ipr_field(int_priority_reg_1, `IPR_FLD_ML);
            dma_chan0_done_level <= ipr_field(int_priority_reg_1, `IPR_FLD_LO);

            uart1_receive_level <= ipr_field(int_priority_reg_2, `IPR_FLD_HI); // [R7]
            spi1_event_level <= ipr_field(int_priority_reg_2, `IPR_FLD_MH);
            spi1_error_level <= ipr_field(int_priority_reg_2, `IPR_FLD_ML);
            timer3_level <= ipr_field(int_priority_reg_2, `IPR_FLD_LO);

            dma_chan1_done_level <= ipr_field(int_priority_reg_3, `IPR_FLD_MH); // [R8]
            adc1_done_level <= ipr_field(int_priority_reg_3, `IPR_FLD_ML);
            uart1_transmit_level <= ipr_field(int_priority_reg_3, `IPR_FLD_LO);

            change_notify_level <= ipr_field(int_priority_reg_4, `IPR_FLD_HI); // [R9]
            comparator_level <= ipr_field(int_priority_reg_4, `IPR_FLD_MH);
            i2c1_master_level <= ipr_field(int_priority_reg_4, `IPR_FLD_ML);
            i2c1_slave_level <= ipr_field(int_priority_reg_4, `IPR_FLD_LO);

            in_capture8_level <= ipr_field(int_priority_reg_5, `IPR_FLD_HI); // [R10]
            in_capture7_level <= ipr_field(int_priority_reg_5, `IPR_FLD_MH);
            ext_irq1_level <= ipr_field(int_priority_reg_5, `IPR_FLD_LO);

            timer4_level <= ipr_field(int_priority_reg_6, `IPR_FLD_HI); // [R11]
            out_compare4_level <= ipr_field(int_priority_reg_6, `IPR_FLD_MH);
            out_compare3_level <= ipr_field(int_priority_reg_6, `IPR_FLD_ML);
            dma_chan2_done_level <= ipr_field(int_priority_reg_6, `IPR_FLD_LO);
        end
    end

    // ======================================================
    // Arbitration of pending requests
    wire win_valid;
    wire [4:0] win_id;
    wire [2:0] win_level;

    ipr_arbiter u_arb (
        .levels(level_vec),
        .req(src_req),
        .win_valid(win_valid),
        .win_id(win_id),
        .win_level(win_level)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_valid <= 1'b0;
            irq_id <= 5'h00;
            irq_level <= 3'h0;
        end else begin
            irq_valid <= win_valid; // [R2] [R12]
            irq_id <= win_id;
            irq_level <= win_level;
        end
    end

    // ======================================================
    // APB read path and answer: one wait-free access phase
    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h00000000;
        case (paddr)
            `IPR_OFF_PRI1: begin
                rd_next = ipr_read(int_priority_reg_1, `IPR_MASK_FULL); // [R3]
            end
            `IPR_OFF_PRI2: begin
                rd_next = ipr_read(int_priority_reg_2, `IPR_MASK_FULL);
            end
            `IPR_OFF_PRI3: begin
                rd_next = ipr_read(int_priority_reg_3, `IPR_MASK_PRI3);
            end
            `IPR_OFF_PRI4: begin
                rd_next = ipr_read(int_priority_reg_4, `IPR_MASK_FULL);
            end
            `IPR_OFF_PRI5: begin
                rd_next = ipr_read(int_priority_reg_5, `IPR_MASK_PRI5);
            end
            `IPR_OFF_PRI6: begin
                rd_next = ipr_read(int_priority_reg_6, `IPR_MASK_FULL);
            end
            `IPR_OFF_PEND: begin
                rd_next = {10'h000, src_req};
            end
            `IPR_OFF_WIN: begin
                rd_next = {23'h000000, irq_valid, irq_level, irq_id};
            end
            default: begin
                rd_next = 32'h00000000;
            end
        endcase
    end

    always @* begin
        state_next = ST_IDLE;
        case (state_reg)
            ST_IDLE: begin
                if (setup) begin
                    state_next = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Zero wait states: the answer stands for the one access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            pready <= (state_next == ST_ANSWER);
            pslverr <= (state_next == ST_ANSWER) && !known_addr(paddr);
            if (state_next == ST_ANSWER && !pwrite) begin
                prdata <= rd_next;
            end else if (state_next != ST_ANSWER) begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule // ipr_regs

/* File: pkg/ipr_map.vh */
// Register map of the six interrupt priority registers
// Assumes an APB slave with 32-bit data, one aligned word per register
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

// ==========================================================
// Byte offsets
`define IPR_OFF_PRI1 12'h000
`define IPR_OFF_PRI2 12'h004
`define IPR_OFF_PRI3 12'h008
`define IPR_OFF_PRI4 12'h00c
`define IPR_OFF_PRI5 12'h010
`define IPR_OFF_PRI6 12'h014
`define IPR_OFF_PEND 12'h018
`define IPR_OFF_WIN 12'h01c

// ==========================================================
// Field positions (low bit of each 3-bit field)
`define IPR_FLD_HI 12
`define IPR_FLD_MH 8
`define IPR_FLD_ML 4
`define IPR_FLD_LO 0
`define IPR_FLD_W 3

// ==========================================================
// Implemented-bit masks and reset values
`define IPR_MASK_FULL 16'h7777
`define IPR_MASK_PRI3 16'h0777
`define IPR_MASK_PRI5 16'h7707
`define IPR_RST_FULL 16'h4444
`define IPR_RST_PRI3 16'h0444
`define IPR_RST_PRI5 16'h4404
`define IPR_LVL_OFF 3'h0
`define IPR_LVL_RST 3'h4

`define IPR_NSRC 22
`endif

/* File: logic/ipr_arbiter.v */
// Picks the highest-level pending source among 22
// Assumes levels and requests on the pclk domain
`timescale 1ns/100ps
`include "ipr_map.vh"
module ipr_arbiter (
    input wire [`IPR_NSRC*3-1:0] levels,
    input wire [`IPR_NSRC-1:0] req,
    output reg win_valid,
    output reg [4:0] win_id,
    output reg [2:0] win_level
);
    integer i;
    reg [2:0] lv;
    always @* begin
        win_valid = 1'b0;
        win_id = 5'h00;
        win_level = 3'h0;
        lv = 3'h0;
        for (i = 0; i < `IPR_NSRC; i = i + 1) begin
            lv = levels[i*3 +: 3];
            // Zero level masks the source; ties go to the lower index
            if (req[i] && lv != `IPR_LVL_OFF && lv > win_level) begin // [R2] [R12]
                win_valid = 1'b1;
                win_id = i[4:0];
                win_level = lv;
            end
        end
    end
endmodule // ipr_arbiter

/* File: verif/ipr_src_model.sv */
// Model of the peripheral sources feeding level requests to the priority block
// Assumes requests are synchronous to pclk and launched just after an edge
`timescale 1ns/100ps
module ipr_src_model (
    input wire pclk,
    input wire presetn,
    input wire [21:0] want,
    output logic [21:0] src_req
);
    // Requests are levels held until the bench withdraws them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) src_req <= 22'h0;
        else src_req <= want;
    end
endmodule // ipr_src_model

/* File: verif/ipr_regs_monitor.sv */
// Concurrent checks on the ports of the priority register block
// Assumes zero-wait APB answers and levels lagging the registers by one cycle
`timescale 1ns/100ps
`include "ipr_map.vh"
module ipr_regs_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [21:0] src_req,
    input wire [2:0] timer2_level,
    input wire [2:0] ext_irq1_level,
    input wire irq_valid,
    input wire [2:0] irq_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_acc = pready && !pwrite;
    wire acc_wr = psel && penable && pready && pwrite;
    ready_follows_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    unused_zero_a: assert property (rd_acc && paddr < `IPR_OFF_PEND |->
        (prdata & ~{16'h0, `IPR_MASK_FULL}) == 32'h0) else $error("unused bits set");
    pri3_top_a: assert property (rd_acc && paddr == `IPR_OFF_PRI3 |->
        prdata[15:11] == 5'h0) else $error("register 3 top bits set");
    pri5_mid_a: assert property (rd_acc && paddr == `IPR_OFF_PRI5 |->
        prdata[7:3] == 5'h0) else $error("register 5 middle bits set");
    unmapped_err_a: assert property (pready && paddr > `IPR_OFF_WIN |->
        pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    timer2_follow_a: assert property (acc_wr && pstrb[1] && paddr == `IPR_OFF_PRI1
        |=> ##1 timer2_level == $past(pwdata[14:12], 2)) else $error("timer2 level wrong");
    ext1_follow_a: assert property (acc_wr && pstrb[0] && paddr == `IPR_OFF_PRI5
        |=> ##1 ext_irq1_level == $past(pwdata[2:0], 2)) else $error("irq1 level wrong");
    disabled_a: assert property (irq_valid |-> irq_level != 3'h0)
        else $error("disabled source forwarded");
    idle_quiet_a: assert property (src_req == 22'h0 |=> !irq_valid)
        else $error("request without source");
    reset_level_a: assert property ($rose(presetn) |->
        timer2_level == 3'h4 && ext_irq1_level == 3'h4) else $error("reset level wrong");
endmodule // ipr_regs_monitor

bind ipr_regs ipr_regs_monitor u_ipr_regs_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .timer2_level(timer2_level), .ext_irq1_level(ext_irq1_level), .irq_valid(irq_valid),
    .irq_level(irq_level));

/* File: verif/ipr_regs_tb.sv */
// Self-checking bench: APB register tests and arbitration through the source model
// Assumes the register map header and a zero-wait APB slave
`timescale 1ns/100ps
`include "ipr_map.vh"
module ipr_regs_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_valid, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [21:0] want, src_req;
    logic [4:0] irq_id;
    logic [2:0] irq_level;
    wire [65:0] lv;
    int error_cnt, compares, i;
    logic [11:0] offs [6] = '{`IPR_OFF_PRI1, `IPR_OFF_PRI2, `IPR_OFF_PRI3,
        `IPR_OFF_PRI4, `IPR_OFF_PRI5, `IPR_OFF_PRI6};
    logic [15:0] msk [6] = '{`IPR_MASK_FULL, `IPR_MASK_FULL, `IPR_MASK_PRI3,
        `IPR_MASK_FULL, `IPR_MASK_PRI5, `IPR_MASK_FULL};
    logic [15:0] wv [6] = '{16'h7531, 16'h1357, 16'h0642, 16'h2460, 16'h6572, 16'h4213};
    // Levels in source index order for the values in wv
    localparam logic [65:0] EXP = {3'h3, 3'h1, 3'h2, 3'h4, 3'h2, 3'h5, 3'h6, 3'h0, 3'h6,
        3'h4, 3'h2, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5, 3'h3, 3'h1, 3'h1, 3'h3, 3'h5, 3'h7};

    ipr_src_model u_ipr_src_model (.pclk(pclk), .presetn(presetn), .want(want),
        .src_req(src_req));
    ipr_regs u_ipr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_req(src_req),
        .timer2_level(lv[2:0]), .out_compare2_level(lv[5:3]), .in_capture2_level(lv[8:6]),
        .dma_chan0_done_level(lv[11:9]), .uart1_receive_level(lv[14:12]),
        .spi1_event_level(lv[17:15]), .spi1_error_level(lv[20:18]),
        .timer3_level(lv[23:21]), .dma_chan1_done_level(lv[26:24]),
        .adc1_done_level(lv[29:27]), .uart1_transmit_level(lv[32:30]),
        .change_notify_level(lv[35:33]), .comparator_level(lv[38:36]),
        .i2c1_master_level(lv[41:39]), .i2c1_slave_level(lv[44:42]),
        .in_capture8_level(lv[47:45]), .in_capture7_level(lv[50:48]),
        .ext_irq1_level(lv[53:51]), .timer4_level(lv[56:54]),
        .out_compare4_level(lv[59:57]), .out_compare3_level(lv[62:60]),
        .dma_chan2_done_level(lv[65:63]), .irq_valid(irq_valid), .irq_id(irq_id),
        .irq_level(irq_level));

    // ==========================================================
    // Tasks
    task stop_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [65:0] got, input logic [65:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 1);
        rd = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, exp);
    endtask
    task arb(input logic [21:0] v, input logic [8:0] exp);
        want <= v;
        repeat (3) @(posedge pclk);
        chk({irq_valid, irq_id, irq_level}, exp);
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end

    // ==========================================================
    // Tests
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, want} = '0;
        error_cnt = 0;
        compares = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk(lv, {22{3'h4}});
        for (i = 0; i < 6; i++) rdc(offs[i], msk[i] & `IPR_RST_FULL);
        for (i = 0; i < 6; i++) begin
            apb(1'b1, offs[i], 32'hffff_ffff, 4'hf);
            rdc(offs[i], msk[i]);
        end
        for (i = 0; i < 6; i++) apb(1'b1, offs[i], {16'hffff, wv[i]}, 4'hf);
        for (i = 0; i < 6; i++) rdc(offs[i], wv[i] & msk[i]);
        chk(lv, EXP);
        arb(22'h004000, 9'h000);
        arb(22'h004089, {1'b1, 5'h00, 3'h7});
        arb(22'h004088, {1'b1, 5'h07, 3'h7});
        arb(22'h004008, {1'b1, 5'h03, 3'h1});
        rdc(`IPR_OFF_PEND, 32'h0000_4008);
        rdc(`IPR_OFF_WIN, 32'h0000_0123);
        arb(22'h0, 9'h000);
        apb(1'b1, `IPR_OFF_PRI1, 32'h0, 4'h1);
        rdc(`IPR_OFF_PRI1, 32'h7500);
        apb(1'b1, 12'h020, 32'hffff_ffff, 4'hf);
        apb(1'b0, 12'h020, 32'h0, 4'h0);
        chk({e, rd}, {1'b1, 32'h0});
        presetn <= 1'b0;
        @(posedge pclk);
        chk(lv, {22{3'h4}});
        presetn <= 1'b1;
        rdc(`IPR_OFF_PRI1, 32'h0000_4444);
        chk(lv, {22{3'h4}});
        stop_test;
    end
endmodule // ipr_regs_tb
